// >>> verilog/trwa_core.sv
`timescale 1ns/100ps
`default_nettype none
module trwa_core #(
  parameter int FIFO_WORDS = trwa_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,                  // 25 MHz system clock
  input wire logic i_sys_rst,              // async reset, active high
  input wire logic i_ce,                   // clock enable, freezes all state when low
  input wire logic i_counter_stage_two,    // control counter stage two level
  input wire logic i_counter_stage_three,  // control counter stage three level
  input wire logic i_timing_track_strobe,  // timing track pulse from the tape, pin
  input wire logic [0:2] i_read_amp,       // read amplifier outputs, pin
  input wire logic i_parity_clear,         // clears accumulator and overrun
  input wire logic i_host_break_ack,       // host takes the offered word
  output logic o_word_transfer_flag,       // break request, word valid
  output trwa_pkg::trwa_word_t o_word,     // offered word with half parities
  output logic [0:5] o_longitudinal_parity, // running xor of checked halves
  output logic o_overrun                   // sticky, a word found the buffer full
);
  import trwa_pkg::*;

  logic strobe_s;
  logic strobe_d;
  logic [0:2] amp_s;
  logic c2_d;
  logic c3_d;
  logic [0:5] six_bit_shift_buffer;
  logic [0:11] word_holding_buffer;
  trwa_fill_t fill;
  logic first_half_done;
  logic par_first;
  logic [0:5] longitudinal_parity_accumulator;
  logic ev_strobe;
  logic c3_fall;
  logic c2_fall;
  logic first_half_event;
  logic second_half_event;
  logic shift_buffer_left_pulse;
  logic buffer_rotation_pulse;
  logic half_full;
  logic push_valid;
  logic push_ready;
  trwa_word_t push_word;
  logic f_out_valid;
  logic f_out_ready;
  trwa_word_t f_out_word;
  logic [WORD_T_BITS-1:0] f_out_bits;

  // pin inputs pass two flops before any logic reads them
  trwa_sync #(.W(1)) u_strobe_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_async(i_timing_track_strobe),
    .o_sync(strobe_s)
  );

  // data and strobe take the same latency, so data is aligned at the edge
  trwa_sync #(.W(GROUP_BITS)) u_amp_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_async(i_read_amp),
    .o_sync(amp_s)
  );

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      strobe_d <= 1'b0;
      c2_d <= 1'b0;
      c3_d <= 1'b0;
    end else if (i_ce) begin
      strobe_d <= strobe_s;
      c2_d <= i_counter_stage_two;
      c3_d <= i_counter_stage_three;
    end
  end

  // only counter stage levels and the strobe start a step
  assign ev_strobe = i_ce && strobe_s && !strobe_d;
  assign c3_fall = i_ce && c3_d && !i_counter_stage_three;
  assign c2_fall = i_ce && c2_d && !i_counter_stage_two;
  // stage three falls together with stage two at the end of a word
  assign first_half_event = c3_fall && !c2_d;
  assign second_half_event = c2_fall;
  assign shift_buffer_left_pulse = ev_strobe && i_counter_stage_three;
  assign buffer_rotation_pulse = first_half_event || second_half_event;
  assign half_full = (fill == ASM_HALF);

  // shift buffer: strobes load positions 3-5, shift pulses move 3-5 to 0-2
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      six_bit_shift_buffer <= SB_RESET;
    end else if (ev_strobe) begin
      if (shift_buffer_left_pulse) begin
        six_bit_shift_buffer[SB_LEFT_LO:SB_LEFT_HI] <=
          six_bit_shift_buffer[SB_RIGHT_LO:SB_RIGHT_HI];
      end
      six_bit_shift_buffer[SB_RIGHT_LO:SB_RIGHT_HI] <= amp_s;
    end
  end

  // a half counts only after a first and then a shifting strobe
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fill <= ASM_NONE;
    end else if (buffer_rotation_pulse) begin
      fill <= ASM_NONE;
    end else if (ev_strobe) begin
      case (fill)
        ASM_NONE: fill <= shift_buffer_left_pulse ? ASM_NONE : ASM_GROUP;
        ASM_GROUP: fill <= shift_buffer_left_pulse ? ASM_HALF : ASM_GROUP;
        ASM_HALF: fill <= shift_buffer_left_pulse ? ASM_NONE : ASM_GROUP;
        default: fill <= ASM_NONE;
      endcase
    end
  end

  // holding buffer changes only on rotation, so strobes leave it alone
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      word_holding_buffer <= DB_RESET;
    end else if (first_half_event && half_full) begin
      word_holding_buffer[DB_UP_LO:DB_UP_HI] <= six_bit_shift_buffer;
    end else if (second_half_event && half_full && first_half_done) begin
      word_holding_buffer[DB_LOW_LO:DB_LOW_HI] <=
        word_holding_buffer[DB_UP_LO:DB_UP_HI];
      word_holding_buffer[DB_UP_LO:DB_UP_HI] <= six_bit_shift_buffer;
    end
  end

  // a word begun mid-way has no first half and is not offered
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      first_half_done <= 1'b0;
    end else if (first_half_event) begin
      first_half_done <= half_full;
    end else if (second_half_event) begin
      first_half_done <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      par_first <= 1'b0;
    end else if (first_half_event && half_full) begin
      par_first <= ^six_bit_shift_buffer;
    end
  end

  // clear and a checked half in one cycle: the half is still folded in
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      longitudinal_parity_accumulator <= LPA_RESET;
    end else if (i_ce) begin
      if (buffer_rotation_pulse && half_full) begin
        longitudinal_parity_accumulator <=
          (i_parity_clear ? LPA_RESET : longitudinal_parity_accumulator)
          ^ six_bit_shift_buffer;
      end else if (i_parity_clear) begin
        longitudinal_parity_accumulator <= LPA_RESET;
      end
    end
  end

  assign o_longitudinal_parity = longitudinal_parity_accumulator;

  // the word pushed is the value the holding buffer takes on this edge
  assign push_valid = second_half_event && half_full && first_half_done;
  assign push_word = '{
    data: {word_holding_buffer[DB_UP_LO:DB_UP_HI], six_bit_shift_buffer},
    par_first: par_first,
    par_second: ^six_bit_shift_buffer
  };

  // tape cannot be stalled, so a full buffer costs the word and flags it
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_overrun <= 1'b0;
    end else if (push_valid && !push_ready) begin
      o_overrun <= 1'b1;
    end else if (i_ce && i_parity_clear) begin
      o_overrun <= 1'b0;
    end
  end

  trwa_fifo #(.W(WORD_T_BITS), .DEPTH(FIFO_WORDS)) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_in_valid(push_valid),
    .o_in_ready(push_ready),
    .i_in_data(push_word),
    .o_out_valid(f_out_valid),
    .i_out_ready(f_out_ready),
    .o_out_data(f_out_bits)
  );

  assign f_out_word = trwa_word_t'(f_out_bits);
  assign f_out_ready = i_ce && (!o_word_transfer_flag || i_host_break_ack);

  // flag stands with its word until the host takes it in a break cycle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_word_transfer_flag <= 1'b0;
      o_word <= WORD_RESET;
    end else if (f_out_ready) begin
      o_word_transfer_flag <= f_out_valid;
      if (f_out_valid) begin
        o_word <= f_out_word;
      end
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // buffer moves are judged one edge after the event that starts them

  a_first_strobe: assert property (
    (ev_strobe && !i_counter_stage_three && !i_counter_stage_two)
      |=> six_bit_shift_buffer[3:5] == $past(amp_s)
        && six_bit_shift_buffer[0:2] == $past(six_bit_shift_buffer[0:2]))
    else $error("first strobe did not load positions 3 to 5");

  a_shift_left_load: assert property (
    (ev_strobe && i_counter_stage_three && !i_counter_stage_two)
      |=> six_bit_shift_buffer[0:2] == $past(six_bit_shift_buffer[3:5])
        && six_bit_shift_buffer[3:5] == $past(amp_s))
    else $error("shift left with load went wrong");

  a_db_kept_strobe: assert property (
    (ev_strobe && !buffer_rotation_pulse) |=> $stable(word_holding_buffer))
    else $error("holding buffer changed on a strobe");

  a_second_shift: assert property (
    (ev_strobe && i_counter_stage_three && i_counter_stage_two)
      ##1 (fill == ASM_HALF) |-> six_bit_shift_buffer[3:5] == $past(amp_s)
        && six_bit_shift_buffer[0:2] == $past(six_bit_shift_buffer[3:5]))
    else $error("second half shift did not load bits 9 to 11");

  a_second_group_load: assert property (
    (ev_strobe && !i_counter_stage_three && i_counter_stage_two && !buffer_rotation_pulse)
      |=> six_bit_shift_buffer[3:5] == $past(amp_s) && $stable(word_holding_buffer))
    else $error("bits 6 to 8 not loaded or holding buffer moved");

  a_first_rotate: assert property (
    (first_half_event && half_full)
      |=> word_holding_buffer[6:11] == $past(six_bit_shift_buffer)
        && par_first == ^$past(six_bit_shift_buffer))
    else $error("first half rotation or parity wrong");

  a_final_rotate: assert property (
    push_valid |=> word_holding_buffer[0:5] == $past(word_holding_buffer[6:11])
      && word_holding_buffer[6:11] == $past(six_bit_shift_buffer))
    else $error("final rotation wrong");

  a_only_timed: assert property (
    (!ev_strobe && !c3_fall && !c2_fall)
      |=> $stable(six_bit_shift_buffer) && $stable(word_holding_buffer))
    else $error("buffers moved without a timing event");

  a_no_partial: assert property (
    (buffer_rotation_pulse && !half_full && !i_parity_clear)
      |=> $stable(word_holding_buffer) && $stable(longitudinal_parity_accumulator))
    else $error("partial half reached the word or the parity");

  a_first_half_kept: assert property (
    (first_half_event && !half_full) |=> !first_half_done)
    else $error("incomplete first half marked as done");

  a_rotate_clears_fill: assert property (
    buffer_rotation_pulse |=> fill == ASM_NONE)
    else $error("fill state survived a rotation");

  a_first_parity_fold: assert property (
    (first_half_event && half_full && !i_parity_clear)
      |=> longitudinal_parity_accumulator
        == ($past(longitudinal_parity_accumulator) ^ $past(six_bit_shift_buffer)))
    else $error("first half not folded into the parity");

  a_second_parity_fold: assert property (
    (second_half_event && half_full && !i_parity_clear)
      |=> longitudinal_parity_accumulator
        == ($past(longitudinal_parity_accumulator) ^ $past(six_bit_shift_buffer)))
    else $error("second half not folded into the parity");

  a_ce_freeze: assert property (
    !i_ce |=> $stable(six_bit_shift_buffer) && $stable(word_holding_buffer)
      && $stable(longitudinal_parity_accumulator) && $stable(fill)
      && $stable(o_word_transfer_flag) && $stable(o_word) && $stable(o_overrun))
    else $error("state moved while the clock enable was low");

  a_flag_request: assert property (
    (push_valid && push_ready && !f_out_valid && !o_word_transfer_flag && i_ce)
      |-> ##[1:3] o_word_transfer_flag)
    else $error("word ready but no break request");

  a_flag_holds: assert property (
    (o_word_transfer_flag && !i_host_break_ack)
      |=> o_word_transfer_flag && $stable(o_word))
    else $error("offered word dropped before the host took it");

  a_flag_needs_word: assert property (
    (!o_word_transfer_flag && !f_out_valid) |=> !o_word_transfer_flag)
    else $error("break requested with no word queued");

  a_host_take: assert property (
    (o_word_transfer_flag && i_host_break_ack && i_ce && !f_out_valid)
      |=> !o_word_transfer_flag)
    else $error("flag stayed up after the host took the last word");

  a_overrun_set: assert property (
    (push_valid && !push_ready) |=> o_overrun)
    else $error("lost word not flagged as overrun");

  a_overrun_sticky: assert property (
    (o_overrun && !(i_ce && i_parity_clear)) |=> o_overrun)
    else $error("overrun dropped without a clear");

  // main scenarios the bench is meant to reach
  c_word_pushed: cover property (push_valid && push_ready);
  c_overrun: cover property (push_valid && !push_ready);
  c_host_take: cover property (o_word_transfer_flag && i_host_break_ack);
  c_partial_half: cover property (buffer_rotation_pulse && !half_full);
  c_ce_hold: cover property (!i_ce && o_word_transfer_flag && i_host_break_ack);
endmodule
`default_nettype wire

// >>> verilog/trwa_pkg.sv
package trwa_pkg;
  localparam int WORD_BITS = 12;
  localparam int HALF_BITS = 6;
  localparam int GROUP_BITS = 3;
  localparam int FIFO_DEPTH = 8;
  // positions inside the six-bit shift buffer
  localparam int SB_LEFT_LO = 0;
  localparam int SB_LEFT_HI = 2;
  localparam int SB_RIGHT_LO = 3;
  localparam int SB_RIGHT_HI = 5;
  // halves of the word holding buffer
  localparam int DB_LOW_LO = 0;
  localparam int DB_LOW_HI = 5;
  localparam int DB_UP_LO = 6;
  localparam int DB_UP_HI = 11;
  localparam logic [0:5] SB_RESET = 6'h00;
  localparam logic [0:11] DB_RESET = 12'h000;
  localparam logic [0:5] LPA_RESET = 6'h00;

  // fill state of the six-bit shift buffer for the current half-word
  typedef enum logic [1:0] {
    ASM_NONE,
    ASM_GROUP,
    ASM_HALF
  } trwa_fill_t;

  // one assembled word as handed to the host; data[0] is word bit 0
  typedef struct packed {
    logic [0:11] data;
    logic par_first;
    logic par_second;
  } trwa_word_t;

  localparam int WORD_T_BITS = $bits(trwa_word_t);
  localparam trwa_word_t WORD_RESET = '{data: 12'h000, par_first: 1'b0, par_second: 1'b0};
endpackage

// >>> verilog/trwa_sync.sv
`timescale 1ns/100ps
`default_nettype none
module trwa_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,           // system clock
  input wire logic i_sys_rst,       // async reset, active high
  input wire logic i_ce,            // clock enable
  input wire logic [W-1:0] i_async, // pin level
  output logic [W-1:0] o_sync       // level after two flops
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else if (i_ce) begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/trwa_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module trwa_fifo #(
  parameter int W = 14,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,          // system clock
  input wire logic i_sys_rst,      // async reset, active high
  input wire logic i_ce,           // clock enable
  input wire logic i_in_valid,     // write request
  output logic o_in_ready,         // room for one more word
  input wire logic [W-1:0] i_in_data, // write data
  output logic o_out_valid,        // a word is waiting
  input wire logic i_out_ready,    // reader takes the word
  output logic [W-1:0] o_out_data  // head word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic do_wr;
  logic do_rd;

  assign o_in_ready = (count != CW'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign do_wr = i_ce && i_in_valid && o_in_ready;
  assign do_rd = i_ce && i_out_ready && o_out_valid;

  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/trwa_tape_model.sv
`timescale 1ns/100ps
`default_nettype none
module trwa_tape_model (
  input wire logic i_clk,       // system clock
  output logic o_strobe,        // timing track pulse
  output logic [0:2] o_amp,     // read amplifier bits
  output logic o_stage_two,     // control counter stage two
  output logic o_stage_three    // control counter stage three
);
  initial begin
    o_strobe = 1'b0;
    o_amp = 3'h0;
    o_stage_two = 1'b0;
    o_stage_three = 1'b0;
  end

  // stage levels move well clear of strobe edges so the synced strobe never races them
  task automatic stage(input logic s3, input logic s2);
    @(posedge i_clk);
    o_stage_three <= s3;
    o_stage_two <= s2;
    repeat (4) @(posedge i_clk);
  endtask

  // amplifier bits are only valid while the strobe is high; afterwards they flip
  // so that a late sample picks up wrong bits instead of a lucky stale value
  task automatic group(input logic [0:2] bits);
    @(posedge i_clk);
    o_amp <= bits;
    o_strobe <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_strobe <= 1'b0;
    o_amp <= ~bits;
    repeat (4) @(posedge i_clk);
  endtask

  task automatic send_word(input logic [0:11] w);
    stage(1'b0, 1'b0);
    group(w[0:2]);
    stage(1'b1, 1'b0);
    group(w[3:5]);
    stage(1'b0, 1'b1);
    group(w[6:8]);
    stage(1'b1, 1'b1);
    group(w[9:11]);
    stage(1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire

// >>> tb/tape_read_word_assembler_test.sv
`timescale 1ns/100ps
`default_nettype none
module tape_read_word_assembler_test;
  import trwa_pkg::*;
  logic i_clk, i_sys_rst, i_ce, i_parity_clear, i_host_break_ack;
  logic strobe, stage_two, stage_three;
  logic [0:2] amp;
  logic o_word_transfer_flag, o_overrun;
  trwa_word_t o_word;
  logic [0:5] o_longitudinal_parity;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  logic [0:11] sent [$];

  trwa_tape_model tape (.i_clk(i_clk), .o_strobe(strobe), .o_amp(amp),
    .o_stage_two(stage_two), .o_stage_three(stage_three));

  trwa_core dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_counter_stage_two(stage_two), .i_counter_stage_three(stage_three),
    .i_timing_track_strobe(strobe), .i_read_amp(amp), .i_parity_clear(i_parity_clear),
    .i_host_break_ack(i_host_break_ack), .o_word_transfer_flag(o_word_transfer_flag),
    .o_word(o_word), .o_longitudinal_parity(o_longitudinal_parity),
    .o_overrun(o_overrun));

  always #20 i_clk = ~i_clk;

  // a full run needs about 1000 cycles
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      $display("Error timeout expected done seen hang");
      test_done();
    end
  end

  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] word_exp(input logic [0:11] w);
    return {2'h0, w, ^w[0:5], ^w[6:11]};
  endfunction

  task automatic send(input logic [0:11] w);
    sent.push_back(w);
    tape.send_word(w);
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    @(negedge i_clk);
    while (o_word_transfer_flag !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
  endtask

  // host holds ack high and takes one word per cycle until the flag drops
  task automatic drain(input int lo, input int hi);
    int n;
    n = 0;
    @(posedge i_clk);
    i_host_break_ack <= 1'b1;
    @(negedge i_clk);
    while (o_word_transfer_flag === 1'b1 && n < sent.size()) begin
      check("word", {2'h0, o_word}, word_exp(sent[n]));
      n++;
      @(negedge i_clk);
    end
    @(posedge i_clk);
    i_host_break_ack <= 1'b0;
    check("drained", {15'h0, n >= lo && n <= hi}, 16'h1);
    sent.delete();
  endtask

  task automatic t_single();
    send(12'hA5C);
    wait_flag();
    check("flag", {15'h0, o_word_transfer_flag}, 16'h1);
    drain(1, 1);
    $display("test single word done");
  endtask

  task automatic t_no_strobe();
    tape.stage(1'b1, 1'b0);
    tape.stage(1'b0, 1'b1);
    tape.stage(1'b1, 1'b1);
    tape.stage(1'b0, 1'b0);
    repeat (6) @(negedge i_clk);
    check("flag idle", {15'h0, o_word_transfer_flag}, 16'h0);
    send(12'h3C6);
    wait_flag();
    drain(1, 1);
    $display("test stages without strobe done");
  endtask

  task automatic t_fill();
    for (int k = 0; k < 8; k++) begin
      send(12'(k * 12'h2C7 + 12'h013));
    end
    check("overrun early", {15'h0, o_overrun}, 16'h0);
    send(12'hFFF);
    send(12'h000);
    check("overrun", {15'h0, o_overrun}, 16'h1);
    // eight words fill the buffer and one more waits in the output register
    drain(9, 9);
    $display("test buffer full done");
  endtask

  task automatic t_parity();
    logic [0:5] lpa;
    @(posedge i_clk);
    i_parity_clear <= 1'b1;
    @(posedge i_clk);
    i_parity_clear <= 1'b0;
    @(negedge i_clk);
    check("lpa clear", {10'h0, o_longitudinal_parity}, 16'h0);
    check("overrun clear", {15'h0, o_overrun}, 16'h0);
    send(12'h9B1);
    send(12'h4E7);
    lpa = sent[0][0:5] ^ sent[0][6:11] ^ sent[1][0:5] ^ sent[1][6:11];
    check("lpa", {10'h0, o_longitudinal_parity}, {10'h0, lpa});
    drain(2, 2);
    $display("test parity done");
  endtask

  // with the enable low a held ack and clear must leave everything frozen
  task automatic t_clock_enable();
    logic [0:5] lpa;
    @(posedge i_clk);
    i_parity_clear <= 1'b1;
    @(posedge i_clk);
    i_parity_clear <= 1'b0;
    send(12'h6D2);
    lpa = sent[0][0:5] ^ sent[0][6:11];
    @(posedge i_clk);
    i_ce <= 1'b0;
    i_host_break_ack <= 1'b1;
    i_parity_clear <= 1'b1;
    repeat (4) @(negedge i_clk);
    check("hold flag", {15'h0, o_word_transfer_flag}, 16'h1);
    check("hold word", {2'h0, o_word}, word_exp(sent[0]));
    check("hold lpa", {10'h0, o_longitudinal_parity}, {10'h0, lpa});
    @(posedge i_clk);
    i_ce <= 1'b1;
    i_host_break_ack <= 1'b0;
    i_parity_clear <= 1'b0;
    drain(1, 1);
    $display("test clock enable done");
  endtask

  initial begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    i_ce = 1'b1;
    i_parity_clear = 1'b0;
    i_host_break_ack = 1'b0;
    repeat (5) @(posedge i_clk);
    check("reset flag", {15'h0, o_word_transfer_flag}, 16'h0);
    check("reset word", {2'h0, o_word}, 16'h0);
    i_sys_rst <= 1'b0;
    t_single();
    t_no_strobe();
    t_fill();
    t_parity();
    t_clock_enable();
    test_done();
  end
endmodule
`default_nettype wire
